// *** hw/sxl_extra_lane.sv ***
// Extra-lane enable logic for serial links A and B: registers, lane clock
// and serializer enables, octet ramp substitution and output buffering.
// Assumes the register port, mode masks and lane data share core_clk.
`timescale 1ns/10ps
`include "sxl_params.svh"

module sxl_extra_lane (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Register port
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [`SXL_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Link configuration
  input wire logic serial_link_master_enable,
  input wire logic [1:0] channel_power_down,
  input wire sxl_pkg::sxl_test_t test_pattern_select,
  input wire sxl_pkg::sxl_lane_vec_t link_a_mode_lanes,
  input wire sxl_pkg::sxl_lane_vec_t link_b_mode_lanes,
  // Link A lane data in
  input wire logic link_a_in_valid,
  output logic link_a_in_ready,
  input wire sxl_pkg::sxl_lane_word_t link_a_in_data,
  // Link B lane data in
  input wire logic link_b_in_valid,
  output logic link_b_in_ready,
  input wire sxl_pkg::sxl_lane_word_t link_b_in_data,
  // Link A lane data out
  output logic link_a_out_valid,
  input wire logic link_a_out_ready,
  output sxl_pkg::sxl_lane_word_t link_a_out_data,
  // Link B lane data out
  output logic link_b_out_valid,
  input wire logic link_b_out_ready,
  output sxl_pkg::sxl_lane_word_t link_b_out_data,
  // Lane controls
  output sxl_pkg::sxl_lane_vec_t link_a_lane_clock_enable,
  output sxl_pkg::sxl_lane_vec_t link_b_lane_clock_enable,
  output sxl_pkg::sxl_lane_vec_t link_a_serializer_enable,
  output sxl_pkg::sxl_lane_vec_t link_b_serializer_enable,
  output sxl_pkg::sxl_lane_vec_t link_a_ramp_lanes,
  output sxl_pkg::sxl_lane_vec_t link_b_ramp_lanes,
  output logic subsystem_power_enable
);

  // ************************************************************
  // Functions
  // ************************************************************

  // Patterns under which extra-only lanes fall back to the ramp
  function automatic logic ramp_fallback(input sxl_pkg::sxl_test_t tp);
    ramp_fallback = (tp == `SXL_TP_NORMAL) || (tp == `SXL_TP_ALT);
  endfunction

  // Extra-lane field with lane 0 forced clear
  function automatic sxl_pkg::sxl_lane_vec_t extra_lanes(
    input logic [7:0] r
  );
    extra_lanes = {r[`SXL_LANE_MSB:`SXL_LANE_LSB], 1'b0};
  endfunction

  // ************************************************************
  // Registers
  // ************************************************************

  logic [7:0] extra_reg [2];
  logic [7:0] rdata_reg;
  wire sel_a = (reg_addr == `SXL_OFS_LINK_A_EXTRA);
  wire sel_b = (reg_addr == `SXL_OFS_LINK_B_EXTRA);
  logic [7:0] rdata_next;

  // Unmapped addresses read zero
  assign rdata_next = sel_a ? extra_reg[0] :
                      sel_b ? extra_reg[1] : 8'h00;

  // register writes
  // No guard on the master enable: software keeps the link idle
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      extra_reg[0] <= `SXL_EXTRA_RESET;
      extra_reg[1] <= `SXL_EXTRA_RESET;
    end else if (reg_wr_en && sel_a) begin
      extra_reg[0] <= reg_wdata;
    end else if (reg_wr_en && sel_b) begin
      extra_reg[1] <= reg_wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rdata_reg <= 8'h00;
    end else if (reg_rd_en) begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

  // ************************************************************
  // Per-link lane logic
  // ************************************************************

  sxl_pkg::sxl_lane_vec_t mode_lanes [2];
  sxl_pkg::sxl_lane_vec_t clk_en_next [2];
  sxl_pkg::sxl_lane_vec_t ser_want [2];
  sxl_pkg::sxl_lane_vec_t ser_en_next [2];
  sxl_pkg::sxl_lane_vec_t ramp_next [2];
  sxl_pkg::sxl_lane_vec_t clk_en_reg [2];
  sxl_pkg::sxl_lane_vec_t ser_en_reg [2];
  sxl_pkg::sxl_lane_vec_t ramp_reg [2];
  sxl_pkg::sxl_octet_t ramp_cnt_reg [2];
  sxl_pkg::sxl_lane_word_t in_data [2];
  sxl_pkg::sxl_lane_word_t stage_data [2];
  logic in_valid [2];
  logic in_ready [2];
  logic link_up [2];
  logic pwr_reg;

  wire both_down = &channel_power_down;

  assign mode_lanes[0] = link_a_mode_lanes;
  assign mode_lanes[1] = link_b_mode_lanes;
  assign in_data[0] = link_a_in_data;
  assign in_data[1] = link_b_in_data;
  assign in_valid[0] = link_a_in_valid;
  assign in_valid[1] = link_b_in_valid;

  genvar l;
  genvar n;
  generate
    for (l = 0; l < 2; l++) begin : g_link
      assign link_up[l] = serial_link_master_enable &
                          !channel_power_down[l] & !both_down;

      assign clk_en_next[l] = link_up[l] ?
        (mode_lanes[l] | extra_lanes(extra_reg[l])) : 8'h00;

      assign ser_want[l] = link_up[l] ?
        (mode_lanes[l] | (extra_reg[l][`SXL_SER_BIT] ?
          extra_lanes(extra_reg[l]) : 8'h00)) : 8'h00;

      assign ser_en_next[l][0] = ser_want[l][0];
      for (n = 1; n < 8; n++) begin : g_chain
        assign ser_en_next[l][n] = ser_want[l][n] & (&ser_want[l][n-1:0]);
      end

      assign ramp_next[l] = ser_en_next[l] &
        ((test_pattern_select == `SXL_TP_RAMP) ? 8'hFF :
         ramp_fallback(test_pattern_select) ?
           (extra_lanes(extra_reg[l]) & ~mode_lanes[l]) : 8'h00);

      for (n = 0; n < 8; n++) begin : g_lane
        assign stage_data[l][n*8 +: 8] =
          !ser_en_next[l][n] ? 8'h00 :
          ramp_next[l][n] ? ramp_cnt_reg[l] : in_data[l][n*8 +: 8];
      end

      always_ff @(posedge core_clk) begin
        if (sys_rst) begin
          clk_en_reg[l] <= 8'h00;
          ser_en_reg[l] <= 8'h00;
          ramp_reg[l] <= 8'h00;
        end else begin
          clk_en_reg[l] <= clk_en_next[l];
          ser_en_reg[l] <= ser_en_next[l];
          ramp_reg[l] <= ramp_next[l];
        end
      end

      // Ramp steps only on accepted words, so stalls do not skip octets
      always_ff @(posedge core_clk) begin
        if (sys_rst || !link_up[l]) begin
          ramp_cnt_reg[l] <= 8'h00;
        end else if (in_valid[l] && in_ready[l]) begin
          ramp_cnt_reg[l] <= ramp_cnt_reg[l] + 8'h01;
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pwr_reg <= 1'b0;
    end else begin
      pwr_reg <= serial_link_master_enable & !both_down;
    end
  end

  assign subsystem_power_enable = pwr_reg;
  assign link_a_lane_clock_enable = clk_en_reg[0];
  assign link_b_lane_clock_enable = clk_en_reg[1];
  assign link_a_serializer_enable = ser_en_reg[0];
  assign link_b_serializer_enable = ser_en_reg[1];
  assign link_a_ramp_lanes = ramp_reg[0];
  assign link_b_ramp_lanes = ramp_reg[1];
  assign link_a_in_ready = in_ready[0];
  assign link_b_in_ready = in_ready[1];

  // ************************************************************
  // Output buffers
  // ************************************************************

  // Two entries let a receiver stall without losing a word
  sxl_skid_buf #(
    .WIDTH(64)
  ) u_buf_a (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .in_valid(link_a_in_valid),
    .in_ready(in_ready[0]),
    .in_data(stage_data[0]),
    .out_valid(link_a_out_valid),
    .out_ready(link_a_out_ready),
    .out_data(link_a_out_data)
  );

  sxl_skid_buf #(
    .WIDTH(64)
  ) u_buf_b (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .in_valid(link_b_in_valid),
    .in_ready(in_ready[1]),
    .in_data(stage_data[1]),
    .out_valid(link_b_out_valid),
    .out_ready(link_b_out_ready),
    .out_data(link_b_out_data)
  );

endmodule

// *** hw/sxl_params.svh ***
// Constants of the extra-lane enable block: offsets, fields, resets, codes.
// Assumes inclusion by its bare name from package and design files.
`ifndef SXL_PARAMS_SVH
`define SXL_PARAMS_SVH

// ************************************************************
// Register offsets
// ************************************************************
`define SXL_ADDR_W 15
`define SXL_OFS_LINK_A_EXTRA 15'h020A
`define SXL_OFS_LINK_B_EXTRA 15'h020B

// ************************************************************
// Fields and resets
// ************************************************************
`define SXL_SER_BIT 0
`define SXL_LANE_LSB 1
`define SXL_LANE_MSB 7
`define SXL_EXTRA_RESET 8'h00

// ************************************************************
// Test pattern codes
// ************************************************************
`define SXL_TP_NORMAL 4'h0
`define SXL_TP_RAMP 4'h4
`define SXL_TP_ALT 4'h5

`endif

// *** hw/sxl_pkg.sv ***
// Types shared by the extra-lane enable block.
// Assumes sxl_params.svh is on the include path.
`include "sxl_params.svh"

package sxl_pkg;
  typedef logic [7:0] sxl_lane_vec_t;
  typedef logic [7:0] sxl_octet_t;
  typedef logic [63:0] sxl_lane_word_t;
  typedef logic [3:0] sxl_test_t;
endpackage

// *** hw/sxl_skid_buf.sv ***
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps

module sxl_skid_buf #(
  parameter int WIDTH = 64
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  logic [1:0] count_reg;
  logic [1:0] count_next;
  logic [WIDTH-1:0] head_reg;
  logic [WIDTH-1:0] tail_reg;
  logic in_ready_reg;
  logic out_valid_reg;
  wire push = in_valid & in_ready_reg;
  wire pop = out_valid_reg & out_ready;

  // Head is the output word, tail catches a word during a stall
  assign count_next = count_reg + {1'b0, push} - {1'b0, pop};
  assign in_ready = in_ready_reg;
  assign out_valid = out_valid_reg;
  assign out_data = head_reg;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      count_reg <= 2'h0;
      in_ready_reg <= 1'b0;
      out_valid_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      in_ready_reg <= (count_next != 2'h2);
      out_valid_reg <= (count_next != 2'h0);
    end
  end

  always_ff @(posedge core_clk) begin
    if (count_reg == 2'h0 && push) begin
      head_reg <= in_data;
    end else if (pop && count_reg == 2'h2) begin
      head_reg <= tail_reg;
    end else if (pop && push) begin
      head_reg <= in_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (push && count_reg == 2'h1 && !pop) begin
      tail_reg <= in_data;
    end
  end

endmodule

// *** testbench/sxl_extra_lane_assertions.sv ***
// Port-level checks for the extra-lane block.
// Assumes a bind into sxl_extra_lane, one clock, sync reset.
`timescale 1ns/10ps
module sxl_extra_lane_chk (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Register port and configuration
  input wire logic reg_rd_en,
  input wire logic [14:0] reg_addr,
  input wire logic [7:0] reg_rdata,
  input wire logic serial_link_master_enable,
  input wire logic [1:0] channel_power_down,
  input wire sxl_pkg::sxl_test_t test_pattern_select,
  input wire sxl_pkg::sxl_lane_vec_t link_a_mode_lanes,
  // Watched outputs
  input wire logic link_a_out_valid,
  input wire logic link_a_out_ready,
  input wire sxl_pkg::sxl_lane_word_t link_a_out_data,
  input wire sxl_pkg::sxl_lane_vec_t link_a_lane_clock_enable,
  input wire sxl_pkg::sxl_lane_vec_t link_a_serializer_enable,
  input wire sxl_pkg::sxl_lane_vec_t link_b_serializer_enable,
  input wire sxl_pkg::sxl_lane_vec_t link_a_ramp_lanes,
  input wire logic subsystem_power_enable
);
  // Past values are only trusted one cycle clear of reset
  logic was_up;
  wire sub_on = serial_link_master_enable & ~&channel_power_down;
  wire up_a = sub_on & ~channel_power_down[0];
  always_ff @(posedge core_clk) was_up <= !sys_rst;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence s_stall;
    link_a_out_valid && !link_a_out_ready;
  endsequence
  property p_hold;
    s_stall |=> link_a_out_valid && $stable(link_a_out_data);
  endproperty
  a_hold: assert property (p_hold) else $error("word lost in stall");
  property p_ser_clk;
    (link_a_serializer_enable & ~link_a_lane_clock_enable) == 8'h00;
  endproperty
  a_ser_clk: assert property (p_ser_clk)
    else $error("serializer on without lane clock");
  property p_chain_a;
    ((link_a_serializer_enable + 8'h01) & link_a_serializer_enable) == 8'h00;
  endproperty
  a_chain_a: assert property (p_chain_a)
    else $error("link A serializer gap");
  property p_chain_b;
    ((link_b_serializer_enable + 8'h01) & link_b_serializer_enable) == 8'h00;
  endproperty
  a_chain_b: assert property (p_chain_b)
    else $error("link B serializer gap");
  property p_mode;
    was_up && $past(up_a) |-> (link_a_lane_clock_enable
      & $past(link_a_mode_lanes)) == $past(link_a_mode_lanes);
  endproperty
  a_mode: assert property (p_mode)
    else $error("mode lane missing");
  property p_pd;
    was_up && !$past(up_a) |-> link_a_lane_clock_enable == 8'h00;
  endproperty
  a_pd: assert property (p_pd)
    else $error("lane on with link down");
  property p_sub;
    was_up |-> subsystem_power_enable == $past(sub_on);
  endproperty
  a_sub: assert property (p_sub)
    else $error("subsystem power wrong");
  property p_ramp4;
    was_up && $past(test_pattern_select) == 4'h4
      |-> link_a_ramp_lanes == link_a_serializer_enable;
  endproperty
  a_ramp4: assert property (p_ramp4)
    else $error("ramp lanes wrong");
  property p_unmap;
    reg_rd_en && reg_addr != 15'h020A && reg_addr != 15'h020B
      |=> reg_rdata == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
endmodule
bind sxl_extra_lane sxl_extra_lane_chk u_chk (.*);

// *** testbench/sxl_rx_model.sv ***
// Receiver at the far end of one lane stream; keeps accepted words.
// Assumes words are taken on the rising edge with valid and ready high.
`timescale 1ns/10ps
module sxl_rx_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Lane stream
  input wire logic valid,
  input wire logic [63:0] data,
  output logic ready,
  // Test control
  input wire logic stall
);
  logic [63:0] q[$];
  // Stall holds ready low so the buffer fills
  assign ready = !stall;
  always @(posedge core_clk) begin
    if (sys_rst)
      q.delete();
    else if (valid && ready)
      q.push_back(data);
  end
endmodule

// *** testbench/tb.sv ***
// Self-checking bench for the extra-lane block.
// Assumes the design files and both receiver models are compiled first.
`timescale 1ns/10ps
module tb;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic wr = 1'b0, rd = 1'b0, men = 1'b0, iv = 1'b0, stall = 1'b1;
  logic [14:0] addr = 15'h0000;
  logic [7:0] wd = 8'h00, ma = 8'h00, mb = 8'h00;
  logic [1:0] pd = 2'b00;
  logic [3:0] tp = 4'h1;
  logic [63:0] id = 64'h0000_0000_0000_0000;
  logic [7:0] rdata, ca, cb, sa, sb, ra, rb;
  logic ira, irb, ova, ovb, ora, orb, sub;
  logic [63:0] oda, odb;
  logic [3:0] tps [4] = '{4'h0, 4'h4, 4'h5, 4'h1};
  logic [7:0] rex [4] = '{8'h0E, 8'h0F, 8'h0E, 8'h00};
  logic [7:0] rbx [4] = '{8'h00, 8'h01, 8'h00, 8'h00};
  int fail_count = 0, n_checks = 0;
  always #5 core_clk = ~core_clk;
  sxl_extra_lane dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .reg_wr_en(wr),
    .reg_rd_en(rd), .reg_addr(addr), .reg_wdata(wd), .reg_rdata(rdata),
    .serial_link_master_enable(men), .channel_power_down(pd),
    .test_pattern_select(tp), .link_a_mode_lanes(ma),
    .link_b_mode_lanes(mb), .link_a_in_valid(iv), .link_a_in_ready(ira),
    .link_a_in_data(id), .link_b_in_valid(iv), .link_b_in_ready(irb),
    .link_b_in_data(id), .link_a_out_valid(ova),
    .link_a_out_ready(ora), .link_a_out_data(oda),
    .link_b_out_valid(ovb), .link_b_out_ready(orb),
    .link_b_out_data(odb), .link_a_lane_clock_enable(ca),
    .link_b_lane_clock_enable(cb), .link_a_serializer_enable(sa),
    .link_b_serializer_enable(sb), .link_a_ramp_lanes(ra),
    .link_b_ramp_lanes(rb), .subsystem_power_enable(sub));
  sxl_rx_model rx_a (.core_clk(core_clk), .sys_rst(sys_rst), .valid(ova),
    .data(oda), .ready(ora), .stall(stall));
  sxl_rx_model rx_b (.core_clk(core_clk), .sys_rst(sys_rst), .valid(ovb),
    .data(odb), .ready(orb), .stall(stall));
  // ************************************************************
  // Access tasks
  // ************************************************************
  task automatic tally_and_finish;
    $display("Compared %0d, mismatched %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // Trailing idle cycle keeps back-to-back strobes apart
  task automatic wr_reg(input logic [14:0] a, input logic [7:0] d);
    addr = a;
    wd = d;
    wr = 1'b1;
    step(1);
    wr = 1'b0;
    step(1);
  endtask
  task automatic rd_reg(input logic [14:0] a, input logic [7:0] e);
    addr = a;
    rd = 1'b1;
    step(1);
    rd = 1'b0;
    chk(rdata, e);
    step(1);
  endtask
  task automatic push(input logic [63:0] d);
    for (int i = 0; i < 50 && !ira; i++) step(1);
    if (!ira) begin
      fail_count++;
      tally_and_finish();
    end
    iv = 1'b1;
    id = d;
    step(1);
    iv = 1'b0;
    step(1);
  endtask
  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    step(3);
    sys_rst = 1'b0;
    step(1);
    rd_reg(15'h020A, 8'h00);
    rd_reg(15'h020B, 8'h00);
    rd_reg(15'h0300, 8'h00);
    $display("reset test done");
    wr_reg(15'h020A, 8'h0E);
    wr_reg(15'h020B, 8'h41);
    ma = 8'h01;
    mb = 8'h01;
    men = 1'b1;
    step(2);
    chk(ca, 8'h0F);
    chk(sa, 8'h01);
    chk(cb, 8'h41);
    chk(sb, 8'h01);
    men = 1'b0;
    wr_reg(15'h020A, 8'h0F);
    wr_reg(15'h020B, 8'h45);
    men = 1'b1;
    step(2);
    chk(sa, 8'h0F);
    chk(sb, 8'h01);
    chk(cb, 8'h45);
    rd_reg(15'h020A, 8'h0F);
    rd_reg(15'h020B, 8'h45);
    $display("enable test done");
    for (int k = 0; k < 4; k++) begin
      tp = tps[k];
      step(2);
      chk(ra, rex[k]);
      chk(rb, rbx[k]);
    end
    $display("ramp test done");
    tp = 4'h0;
    step(2);
    push(64'hA5A5_A5A5_A5A5_A5C3);
    push(64'h5A5A_5A5A_5A5A_5A3C);
    chk({ira, irb}, 2'b00);
    stall = 1'b0;
    step(4);
    chk(rx_a.q.size(), 2);
    chk(rx_a.q[0][63:32], 32'h0000_0000);
    chk(rx_a.q[0][7:0], 8'hC3);
    chk(rx_a.q[0][31:8], 24'h00_0000);
    chk(rx_a.q[1][31:8], 24'h01_0101);
    chk(rx_a.q[1][7:0], 8'h3C);
    chk(rx_b.q[0], 64'h0000_0000_0000_00C3);
    chk(rx_b.q[1], 64'h0000_0000_0000_003C);
    $display("stream test done");
    pd = 2'b01;
    step(2);
    chk(ca, 8'h00);
    chk(cb, 8'h45);
    pd = 2'b11;
    step(2);
    chk({sub, cb}, 9'h000);
    sys_rst = 1'b1;
    step(2);
    sys_rst = 1'b0;
    step(1);
    rd_reg(15'h020A, 8'h00);
    $display("power and reset test done");
    tally_and_finish();
  end
endmodule
